// ### tb/cfg_fabric_model.sv
// Fabric-side model that presents a word with a one-cycle update strobe
module cfg_fabric_model import pll_cfg_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request from the bench
	input wire logic load,
	input wire logic [CFG_MSB:CFG_LSB] word,
	// Toward the block
	output logic [CFG_MSB:CFG_LSB] cfg_word,
	output logic cfg_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Word toggles off the strobe edge so a late sample is caught
	always @(posedge clk) begin
		if (!rst_n) begin
			cfg_strobe <= 1'h0;
			cfg_word <= '0;
		end else begin
			cfg_strobe <= load;
			cfg_word <= load ? word : ~cfg_word;
		end
	end
endmodule

// ### tb/pll_cfg_checker.sv
// Port-level assertions for the configuration word block
module pll_cfg_checker import pll_cfg_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Watched ports
	input wire logic [CFG_MSB:CFG_LSB] CONFIG_WORD,
	input wire logic CONFIG_UPDATE_STROBE,
	input wire logic REFERENCE_OUT,
	input wire logic FEEDBACK_OUT,
	input wire logic [2:0] OSC_GEAR_RANGE,
	input wire logic LOCK,
	input wire logic DIVIDER_SYNC_ENABLE,
	input wire logic DIVIDER_SYNC_PULSE,
	input wire logic [CFG_MSB:CFG_LSB] CONFIG_READBACK
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ------------------------------------------------
	// Update and lock properties
	// ------------------------------------------------
	sequence s_take;
		CONFIG_UPDATE_STROBE;
	endsequence
	sequence s_quiet;
		!CONFIG_UPDATE_STROBE ##1 !CONFIG_UPDATE_STROBE;
	endsequence
	chk_pulse_after: assert property (s_take |=> DIVIDER_SYNC_PULSE)
		else $error("sync pulse missing");
	chk_pulse_cause: assert property (DIVIDER_SYNC_PULSE |-> $past(CONFIG_UPDATE_STROBE))
		else $error("sync pulse without strobe");
	chk_word_load: assert property (s_take |-> ##2
		{CONFIG_READBACK[88:81], CONFIG_READBACK[79:32]} ==
		$past({CONFIG_WORD[88:81], CONFIG_WORD[79:32]}, 2))
		else $error("readback differs from loaded word");
	chk_word_hold: assert property (s_quiet |=> $stable(CONFIG_READBACK))
		else $error("readback moved without strobe");
	chk_sync_fixed: assert property (DIVIDER_SYNC_ENABLE && CONFIG_READBACK[80])
		else $error("sync enable not held high");
	chk_gear_copy: assert property (OSC_GEAR_RANGE == CONFIG_READBACK[76:74])
		else $error("gear output differs from word");
	chk_reset_vals: assert property ($rose(RST_N) |-> !LOCK && OSC_GEAR_RANGE == 3'h0 &&
		CONFIG_READBACK[79:32] == '0)
		else $error("wrong state after reset");
	chk_ref_gate: assert property (!CONFIG_READBACK[77] && !$past(CONFIG_READBACK[77])
		|-> !REFERENCE_OUT)
		else $error("reference active while gated");
	chk_lock_drop: assert property ($past(LOCK) && ($rose(REFERENCE_OUT) != $rose(FEEDBACK_OUT))
		|-> !LOCK)
		else $error("lock held over unmatched edge");
endmodule

bind pll_config_word_fields pll_cfg_checker u_pll_cfg_checker (.CLK(CLK), .RST_N(RST_N),
	.CONFIG_WORD(CONFIG_WORD), .CONFIG_UPDATE_STROBE(CONFIG_UPDATE_STROBE),
	.REFERENCE_OUT(REFERENCE_OUT), .FEEDBACK_OUT(FEEDBACK_OUT),
	.OSC_GEAR_RANGE(OSC_GEAR_RANGE), .LOCK(LOCK), .DIVIDER_SYNC_ENABLE(DIVIDER_SYNC_ENABLE),
	.DIVIDER_SYNC_PULSE(DIVIDER_SYNC_PULSE), .CONFIG_READBACK(CONFIG_READBACK));

// ### tb/pll_config_word_fields_bench.sv
// Self-checking bench for the configuration word block
module pll_config_word_fields_bench import pll_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic load = 1'h0;
	logic [88:32] word = '0;
	logic [9:0] src = '0;
	logic [88:32] cfg_word;
	logic cfg_strobe;
	wire [6:0] outs;
	logic [2:0] gear;
	logic lock;
	logic sync_en;
	logic pulse;
	logic [88:32] readback;
	int n_errors = 0;
	int compares = 0;
	int lr;
	int lf;
	int n;

	cfg_fabric_model u_cfg_fabric_model (.clk(clk), .rst_n(rst_n), .load(load), .word(word),
		.cfg_word(cfg_word), .cfg_strobe(cfg_strobe));
	pll_config_word_fields u_pll_config_word_fields (.CLK(clk), .RST_N(rst_n),
		.CONFIG_WORD(cfg_word), .CONFIG_UPDATE_STROBE(cfg_strobe),
		.CLOCK_INPUT_A(src[4]), .CLOCK_INPUT_B(src[5]), .CLOCK_INPUT_C(src[6]),
		.RC_OSC(src[7]), .XTAL_OSC(src[8]), .EXT_FEEDBACK(src[9]), .OSC_PHASES(src[3:0]),
		.GLOBAL_OUT1(outs[0]), .GLOBAL_OUT2(outs[1]), .GLOBAL_OUT3(outs[2]),
		.ROUTED_OUT3(outs[3]), .ROUTED_OUT2(outs[4]), .FEEDBACK_OUT(outs[5]),
		.REFERENCE_OUT(outs[6]), .OSC_GEAR_RANGE(gear), .LOCK(lock),
		.DIVIDER_SYNC_ENABLE(sync_en), .DIVIDER_SYNC_PULSE(pulse), .CONFIG_READBACK(readback));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("compares=%0d errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	function automatic logic [88:32] fld(input int lo, input int v);
		return 57'(v) << (lo - 32);
	endfunction
	task automatic apply(input logic [88:32] w);
		word = w;
		load = 1'h1;
		step(1);
		load = 1'h0;
		step(1);
		check(pulse, 1'h1);
		step(2);
	endtask
	// Flush lines, raise one source, count cycles to the output edge
	task automatic meas(input logic [88:32] w, input int pin, input int o, input bit must,
		output int cnt);
		src = '0;
		apply(w);
		step(36);
		src[pin] = 1'h1;
		cnt = 0;
		while (cnt < 60 && outs[o] !== 1'h1) begin
			step(1);
			cnt++;
		end
		src = '0;
		if (must && cnt == 60) begin
			n_errors++;
			test_done();
		end
	endtask
	task automatic do_reset();
		rst_n = 1'h0;
		step(16);
		rst_n = 1'h1;
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_reset();
		check(readback, fld(80, 1));
		check(sync_en, 1'h1);
		check(lock, 1'h0);
		$display("reset done");
	endtask
	task automatic t_word();
		logic [88:32] w;
		w = 57'h1AAAAAAAAAAAAAA;
		repeat (2) begin
			apply(w);
			check(readback, w | fld(80, 1));
			check(gear, w[76:74]);
			w = ~w;
		end
		$display("word done");
	endtask
	task automatic t_paths();
		logic [88:32] w [10];
		int pin [10] = '{0, 0, 0, 3, 3, 2, 0, 6, 8, 7};
		int o [10] = '{0, 0, 0, 1, 4, 3, 2, 2, 1, 2};
		int e [10] = '{2, 9, 33, 11, 6, 3, 4, 5, 2, 2};
		w = '{fld(46, 0), fld(46, 7), fld(46, 31), fld(32, 3) | fld(51, 9),
			fld(32, 3) | fld(61, 4), fld(35, 2) | fld(66, 1), fld(35, 6) | fld(56, 2),
			fld(79, 1) | fld(56, 3), fld(78, 1) | fld(72, 1) | fld(82, 1), fld(79, 1) | fld(73, 1)};
		foreach (w[i]) begin
			meas(w[i], pin[i], o[i], 1'h1, n);
			check(n, e[i]);
		end
		$display("paths done");
	endtask
	task automatic t_feedback();
		meas(fld(38, 0), 0, 5, 1'h1, lf);
		meas(fld(38, 1) | fld(40, 5), 0, 5, 1'h1, n);
		check(n, lf + 6);
		meas(fld(38, 1) | fld(40, 5) | fld(45, 1), 0, 5, 1'h1, n);
		check(n, lf + 10);
		meas(fld(38, 2), 9, 5, 1'h1, n);
		check(n, lf);
		meas(fld(38, 3), 0, 5, 1'h1, n);
		check(n, lf);
		meas(fld(77, 1), 4, 6, 1'h1, lr);
		meas(fld(77, 1) | fld(71, 1) | fld(81, 1), 8, 6, 1'h1, n);
		check(n, lr);
		meas(fld(77, 0), 4, 6, 1'h0, n);
		check(n, 60);
		$display("feedback done");
	endtask
	// Skew the two sources so reference and feedback edges meet inside
	task automatic t_lock();
		int ph;
		apply(fld(77, 1));
		for (ph = 0; ph < 200; ph++) begin
			src[4] = 1'((ph - lf) >> 2);
			src[0] = 1'((ph - lr - (ph >= 160 ? 1 : 0)) >> 2);
			step(1);
			if (ph == 159) begin
				check(lock, 1'h1);
			end
		end
		check(lock, 1'h0);
		src = '0;
		$display("lock done");
	endtask

	initial begin
		do_reset();
		t_reset();
		t_word();
		t_paths();
		t_feedback();
		t_lock();
		do_reset();
		t_reset();
		test_done();
	end
endmodule

// ### verilog/pll_cfg_pkg.sv
// Field layout, reset values and timing counts of the loop configuration word
package pll_cfg_pkg;

	// ----------------------------------------------------------------
	// Word geometry
	// ----------------------------------------------------------------
	localparam int CFG_MSB = 88;
	localparam int CFG_LSB = 32;
	localparam int CFG_W = CFG_MSB - CFG_LSB + 1;

	// ----------------------------------------------------------------
	// Field positions (absolute bit numbers)
	// ----------------------------------------------------------------
	localparam int OSC_SRC_SEL_C_BIT = 83;
	localparam int OSC_SRC_SEL_B_BIT = 82;
	localparam int OSC_SRC_SEL_A_BIT = 81;
	localparam int DIVIDER_SYNC_BIT = 80;
	localparam int DYN_ROUTE_C_BIT = 79;
	localparam int DYN_ROUTE_B_BIT = 78;
	localparam int DYN_ROUTE_A_BIT = 77;
	localparam int GEAR_HI = 76;
	localparam int GEAR_LO = 74;
	localparam int STATIC_MUX_C_BIT = 73;
	localparam int STATIC_MUX_B_BIT = 72;
	localparam int STATIC_MUX_A_BIT = 71;
	localparam int ROUTED3_DLY_LO = 66;
	localparam int ROUTED2_DLY_LO = 61;
	localparam int GLOBAL3_DLY_LO = 56;
	localparam int GLOBAL2_DLY_LO = 51;
	localparam int GLOBAL1_DLY_LO = 46;
	localparam int SYS_DLY_BIT = 45;
	localparam int FB_DLY_LO = 40;
	localparam int FB_SEL_HI = 39;
	localparam int FB_SEL_LO = 38;
	localparam int TAP3_HI = 37;
	localparam int TAP3_LO = 35;
	localparam int TAP2_HI = 34;
	localparam int TAP2_LO = 32;
	localparam int VARIANT_LO = 81;
	localparam int DLY_W = 5;
	localparam int DLY_TAPS = 32;
	localparam int NUM_DLY = 6;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] FB_NO_DELAY = 2'h0;
	localparam logic [1:0] FB_PROG_DELAY = 2'h1;
	localparam logic [1:0] FB_EXTERNAL = 2'h2;
	localparam logic [CFG_W-1:0] CFG_RESET = '0;
	localparam logic DIVIDER_SYNC_RESET = 1'h1;
	localparam logic [2:0] TAP_COUNT = 3'h4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYS_DELAY_NS = 40;
	localparam int SYS_DELAY_CYC = (SYS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] LOCK_EDGES = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] osc_src_sel;
		logic [2:0] dyn_route;
		logic [2:0] osc_gear_range;
		logic [2:0] static_mux;
		logic [DLY_W-1:0] routed_out3_delay;
		logic [DLY_W-1:0] routed_out2_delay;
		logic [DLY_W-1:0] global_out3_delay;
		logic [DLY_W-1:0] global_out2_delay;
		logic [DLY_W-1:0] global_out1_delay;
		logic system_delay_insert;
		logic [DLY_W-1:0] feedback_delay_value;
		logic [1:0] feedback_path_select;
		logic [2:0] phase_tap_out3;
		logic [2:0] phase_tap_out2;
	} cfg_fields_t;

	typedef enum logic [1:0] {
		LK_IDLE = 2'h0,
		LK_ACQUIRE = 2'h1,
		LK_LOCKED = 2'h3
	} lock_state_t;

endpackage

// ### verilog/pll_config_word_fields.sv
// Configuration word decode, clock steering, delay taps and lock detection
module pll_config_word_fields import pll_cfg_pkg::*; #(
	parameter bit MIXED_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Configuration word
	input wire logic [CFG_MSB:CFG_LSB] CONFIG_WORD,
	input wire logic CONFIG_UPDATE_STROBE,
	// Clock sources, sampled levels
	input wire logic CLOCK_INPUT_A,
	input wire logic CLOCK_INPUT_B,
	input wire logic CLOCK_INPUT_C,
	input wire logic RC_OSC,
	input wire logic XTAL_OSC,
	input wire logic EXT_FEEDBACK,
	input wire logic [3:0] OSC_PHASES,
	// Clock outputs
	output logic GLOBAL_OUT1,
	output logic GLOBAL_OUT2,
	output logic GLOBAL_OUT3,
	output logic ROUTED_OUT2,
	output logic ROUTED_OUT3,
	// Loop controls and status
	output logic REFERENCE_OUT,
	output logic FEEDBACK_OUT,
	output logic [2:0] OSC_GEAR_RANGE,
	output logic LOCK,
	output logic DIVIDER_SYNC_ENABLE,
	output logic DIVIDER_SYNC_PULSE,
	output logic [CFG_MSB:CFG_LSB] CONFIG_READBACK
);

	// ----------------------------------------------------------------
	// Configuration shadow
	// ----------------------------------------------------------------
	logic [CFG_MSB:CFG_LSB] cfg_ff;
	logic sync_en_ff;
	logic [CFG_MSB:CFG_LSB] nxt_cfg;
	cfg_fields_t f;

	always_comb begin
		nxt_cfg = CONFIG_WORD;
		nxt_cfg[DIVIDER_SYNC_BIT] = 1'b0;
		if (!MIXED_VARIANT) begin
			nxt_cfg[CFG_MSB:VARIANT_LO] = '0;
		end
	end

	// Whole word is taken at once so the loop never sees a half-applied set
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cfg_ff <= CFG_RESET;
		end else if (CONFIG_UPDATE_STROBE) begin
			cfg_ff <= nxt_cfg;
		end
	end

	// Software cannot write the sync flag; it only reads it back
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sync_en_ff <= DIVIDER_SYNC_RESET;
		end
	end

	always_comb begin
		f.osc_src_sel = {cfg_ff[OSC_SRC_SEL_C_BIT], cfg_ff[OSC_SRC_SEL_B_BIT],
			cfg_ff[OSC_SRC_SEL_A_BIT]};
		f.dyn_route = {cfg_ff[DYN_ROUTE_C_BIT], cfg_ff[DYN_ROUTE_B_BIT],
			cfg_ff[DYN_ROUTE_A_BIT]};
		f.osc_gear_range = cfg_ff[GEAR_HI:GEAR_LO];
		f.static_mux = {cfg_ff[STATIC_MUX_C_BIT], cfg_ff[STATIC_MUX_B_BIT],
			cfg_ff[STATIC_MUX_A_BIT]};
		f.routed_out3_delay = cfg_ff[ROUTED3_DLY_LO +: DLY_W];
		f.routed_out2_delay = cfg_ff[ROUTED2_DLY_LO +: DLY_W];
		f.global_out3_delay = cfg_ff[GLOBAL3_DLY_LO +: DLY_W];
		f.global_out2_delay = cfg_ff[GLOBAL2_DLY_LO +: DLY_W];
		f.global_out1_delay = cfg_ff[GLOBAL1_DLY_LO +: DLY_W];
		f.system_delay_insert = cfg_ff[SYS_DLY_BIT];
		f.feedback_delay_value = cfg_ff[FB_DLY_LO +: DLY_W];
		f.feedback_path_select = cfg_ff[FB_SEL_HI:FB_SEL_LO];
		f.phase_tap_out3 = cfg_ff[TAP3_HI:TAP3_LO];
		f.phase_tap_out2 = cfg_ff[TAP2_HI:TAP2_LO];
	end

	// ----------------------------------------------------------------
	// Input source selection
	// ----------------------------------------------------------------
	logic [2:0] pins;
	logic [2:0] src;
	logic ref_clk;

	assign pins = {CLOCK_INPUT_C, CLOCK_INPUT_B, CLOCK_INPUT_A};

	// Static mux set: take the on-chip oscillator chosen by the source bit
	generate
		for (genvar i = 0; i < 3; i++) begin : g_src
			assign src[i] = f.static_mux[i] ?
				(f.osc_src_sel[i] ? XTAL_OSC : RC_OSC) : pins[i];
		end
	endgenerate

	// Without the dynamic select the loop reference is held quiet
	assign ref_clk = f.dyn_route[0] & src[0];

	// ----------------------------------------------------------------
	// Phase taps
	// ----------------------------------------------------------------
	logic tap3;
	logic tap2;

	// Codes beyond the four taps fall back to tap zero
	function automatic logic pick_tap(input logic [2:0] sel, input logic [3:0] ph);
		pick_tap = (sel < TAP_COUNT) ? ph[sel[1:0]] : ph[0];
	endfunction

	assign tap3 = pick_tap(f.phase_tap_out3, OSC_PHASES);
	assign tap2 = pick_tap(f.phase_tap_out2, OSC_PHASES);

	// ----------------------------------------------------------------
	// Programmable delay lines: 1 + setting cycles each
	// ----------------------------------------------------------------
	logic [NUM_DLY-1:0] dly_in;
	logic [NUM_DLY-1:0] dly_out;
	logic [NUM_DLY-1:0][DLY_W-1:0] dly_sel;
	logic [NUM_DLY-1:0][DLY_TAPS-1:0] line_ff;
	logic g3_src;
	logic g2_src;

	assign g3_src = f.dyn_route[2] ? src[2] : tap3;
	assign g2_src = f.dyn_route[1] ? src[1] : tap2;
	assign dly_in = {OSC_PHASES[0], OSC_PHASES[0], g2_src, g3_src, tap2, tap3};
	assign dly_sel = {f.feedback_delay_value, f.global_out1_delay, f.global_out2_delay,
		f.global_out3_delay, f.routed_out2_delay, f.routed_out3_delay};

	generate
		for (genvar d = 0; d < NUM_DLY; d++) begin : g_dly
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					line_ff[d] <= '0;
				end else begin
					line_ff[d] <= {line_ff[d][DLY_TAPS-2:0], dly_in[d]};
				end
			end
			assign dly_out[d] = line_ff[d][dly_sel[d]];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Feedback path
	// ----------------------------------------------------------------
	logic [SYS_DELAY_CYC-1:0] sys_dly_ff;
	logic fb_mux;
	logic fb_clk;

	always_comb begin
		unique case (f.feedback_path_select)
			FB_PROG_DELAY: fb_mux = dly_out[5];
			FB_EXTERNAL: fb_mux = EXT_FEEDBACK;
			default: fb_mux = OSC_PHASES[0];
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sys_dly_ff <= '0;
		end else begin
			sys_dly_ff <= {sys_dly_ff[SYS_DELAY_CYC-2:0], fb_mux};
		end
	end

	// Top bit holds the feedback seen SYS_DELAY_CYC cycles ago
	assign fb_clk = f.system_delay_insert ? sys_dly_ff[SYS_DELAY_CYC-1] : fb_mux;

	// ----------------------------------------------------------------
	// Lock detector
	// ----------------------------------------------------------------
	lock_state_t lk_ff;
	logic [3:0] match_ff;
	logic ref_d_ff;
	logic fb_d_ff;
	logic ref_rise;
	logic fb_rise;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ref_d_ff <= 1'b0;
			fb_d_ff <= 1'b0;
		end else begin
			ref_d_ff <= ref_clk;
			fb_d_ff <= fb_clk;
		end
	end

	assign ref_rise = ref_clk & ~ref_d_ff;
	assign fb_rise = fb_clk & ~fb_d_ff;

	// Equal edge timing every period means frequency and phase agree
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			lk_ff <= LK_IDLE;
			match_ff <= '0;
		end else if (ref_rise != fb_rise) begin
			lk_ff <= LK_IDLE;
			match_ff <= '0;
		end else if (ref_rise) begin
			unique case (lk_ff)
				LK_IDLE: begin
					lk_ff <= LK_ACQUIRE;
					match_ff <= 4'h1;
				end
				LK_ACQUIRE: begin
					match_ff <= match_ff + 4'h1;
					if (match_ff + 4'h1 == LOCK_EDGES) begin
						lk_ff <= LK_LOCKED;
					end
				end
				LK_LOCKED: lk_ff <= LK_LOCKED;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ROUTED_OUT3 <= 1'b0;
			ROUTED_OUT2 <= 1'b0;
			GLOBAL_OUT3 <= 1'b0;
			GLOBAL_OUT2 <= 1'b0;
			GLOBAL_OUT1 <= 1'b0;
		end else begin
			ROUTED_OUT3 <= dly_out[0];
			ROUTED_OUT2 <= dly_out[1];
			GLOBAL_OUT3 <= dly_out[2];
			GLOBAL_OUT2 <= dly_out[3];
			GLOBAL_OUT1 <= dly_out[4];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			REFERENCE_OUT <= 1'b0;
			FEEDBACK_OUT <= 1'b0;
			OSC_GEAR_RANGE <= '0;
			LOCK <= 1'b0;
		end else begin
			REFERENCE_OUT <= ref_clk;
			FEEDBACK_OUT <= fb_clk;
			OSC_GEAR_RANGE <= f.osc_gear_range;
			LOCK <= (lk_ff == LK_LOCKED) && (ref_rise == fb_rise);
		end
	end

	// Dividers are realigned in the same cycle that a new word lands in cfg_ff
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DIVIDER_SYNC_ENABLE <= DIVIDER_SYNC_RESET;
			DIVIDER_SYNC_PULSE <= 1'b0;
		end else begin
			DIVIDER_SYNC_ENABLE <= sync_en_ff;
			DIVIDER_SYNC_PULSE <= CONFIG_UPDATE_STROBE & sync_en_ff;
		end
	end

	// ----------------------------------------------------------------
	// Readback
	// ----------------------------------------------------------------
	// Bit 80 reads the sync flag even while reset is held
	localparam logic [CFG_MSB:CFG_LSB] READBACK_RESET =
		CFG_RESET | (CFG_W'(DIVIDER_SYNC_RESET) << (DIVIDER_SYNC_BIT - CFG_LSB));
	logic [CFG_MSB:CFG_LSB] sync_bit;

	assign sync_bit = CFG_W'(sync_en_ff) << (DIVIDER_SYNC_BIT - CFG_LSB);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			CONFIG_READBACK <= READBACK_RESET;
		end else begin
			CONFIG_READBACK <= cfg_ff | sync_bit;
		end
	end

endmodule
